// [shared/usdba_consts.svh]
// usdba_consts.svh: register offsets, field positions, reset values and counts
// assumes inclusion by bare name from the package; the design modules see its macros through the package
`ifndef USDBA_CONSTS_SVH
`define USDBA_CONSTS_SVH

// register byte offsets on the apb bus
`define USDBA_OFS_DATA 8'h00
`define USDBA_OFS_LINE_CTRL 8'h04
`define USDBA_OFS_MODEM 8'h08
`define USDBA_OFS_RX_COUNT 8'h0c
`define USDBA_OFS_TX_COUNT 8'h10
`define USDBA_OFS_DIVISOR 8'h14
`define USDBA_OFS_PRESCALER 8'h18
`define USDBA_OFS_STATION 8'h1c
`define USDBA_OFS_EVENTS 8'h20

// reset values
`define USDBA_RST_LINE_CTRL 8'h00
`define USDBA_RST_DIVISOR 16'h0001
`define USDBA_RST_PRESCALER 8'h01
`define USDBA_RST_STATION 8'hff
`define USDBA_RST_COUNT 4'h0

// field values and positions
`define USDBA_NO_ADDRESS 8'hff
`define USDBA_PRESC_MASK 8'h7f
`define USDBA_EV_MATCH 0
`define USDBA_EV_OVERRUN 1
`define USDBA_EV_RX_READY 2
`define USDBA_EV_TX_EMPTY 3

// fifo depth and oversampling
`define USDBA_FIFO_DEPTH 4'h8
`define USDBA_FIFO_ONE 4'h1
`define USDBA_HALF_BIT 4'h7
`define USDBA_FULL_BIT 4'hf
`define USDBA_MIN_BITS 3'h4

`endif

// [shared/usdba_pkg.sv]
// usdba_pkg: types shared by the serial port modules
// assumes usdba_consts.svh is on the include path
package usdba_pkg;
  `include "usdba_consts.svh"

  // line control layout: stop, parity, fifo and flow options
  typedef struct packed {
    logic auto_flow;
    logic fifo_en;
    logic [1:0] parity_kind_sel;
    logic parity_enable;
    logic two_stop;
    logic [1:0] word_length_sel;
  } usdba_line_ctrl_t;

  // modem inputs, active level already applied (1 = asserted)
  typedef struct packed {
    logic carrier;
    logic ring;
    logic set_ready;
    logic send_clear;
  } usdba_modem_t;

  typedef enum logic [4:0] {
    SER_IDLE = 5'h01,
    SER_START = 5'h02,
    SER_DATA = 5'h04,
    SER_PAR = 5'h08,
    SER_STOP = 5'h10
  } usdba_ser_state_t;
endpackage : usdba_pkg

// [core/usdba_fifo.sv]
// usdba_fifo: eight-entry byte fifo with occupancy count
// assumes push is only offered when full_out is low
`timescale 1ns/1ps
module usdba_fifo
  import usdba_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // control
  input wire logic push_in,
  input wire logic [7:0] data_in,
  input wire logic pop_in,
  input wire logic [3:0] limit_in,
  // status
  output logic [7:0] data_out,
  output logic [3:0] count_out,
  output logic full_out,
  output logic empty_out
);
  logic [7:0] mem_reg [0:7];
  logic [2:0] wr_ptr_reg;
  logic [2:0] rd_ptr_reg;
  logic do_pop;

  assign do_pop = pop_in && !empty_out;
  assign full_out = count_out >= limit_in;
  assign empty_out = count_out == `USDBA_RST_COUNT;
  assign data_out = mem_reg[rd_ptr_reg];

  always_ff @(posedge sys_clk_in) begin
    if (push_in && !full_out) begin
      mem_reg[wr_ptr_reg] <= data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      wr_ptr_reg <= 3'h0;
      rd_ptr_reg <= 3'h0;
      count_out <= `USDBA_RST_COUNT;
    end else begin
      if (push_in && !full_out) begin
        wr_ptr_reg <= wr_ptr_reg + 3'h1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 3'h1;
      end
      count_out <= count_out + {3'h0, push_in && !full_out} - {3'h0, do_pop};
    end
  end
endmodule : usdba_fifo

// [core/usdba_baud.sv]
// usdba_baud: sixteen-times bit-rate enable from prescaler and divisor
// assumes one system clock; a zero prescaler or divisor stops the enable
`timescale 1ns/1ps
module usdba_baud
  import usdba_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // settings
  input wire logic [7:0] presc_in,
  input wire logic [15:0] divisor_in,
  // enable
  output logic tick_out
);
  // rate 2*fsys/(presc*div): adding 2 per cycle modulo presc*div
  logic [22:0] limit;
  logic [23:0] acc_reg;
  logic [23:0] acc_sum;

  assign limit = {16'h0000, presc_in[6:0]} * {7'h00, divisor_in};
  assign acc_sum = acc_reg + 24'h000002;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      acc_reg <= 24'h000000;
      tick_out <= 1'b0;
    end else if (limit == 23'h000000) begin
      acc_reg <= 24'h000000;
      tick_out <= 1'b0;
    end else if (acc_sum >= {1'b0, limit}) begin
      // limit one would want two ticks a cycle; cap at one
      acc_reg <= (acc_sum - {1'b0, limit} >= {1'b0, limit}) ? 24'h000000 : acc_sum - {1'b0, limit};
      tick_out <= 1'b1;
    end else begin
      acc_reg <= acc_sum;
      tick_out <= 1'b0;
    end
  end
endmodule : usdba_baud

// [core/usdba_top.sv]
// usdba_top: asynchronous serial port with fifos, baud divider,
// modem status and multi-drop station address matching
// assumes an apb master on the system clock and line pins synchronous to it
//
// Behaviour
// - modem status bits 7..4 show carrier, ring, set ready, send clear; 1 when pin low
// - modem status bits 3..0 latch on input change and clear on read
// - modem status and address matching exist only on the primary port
// - receive buffer read returns the 8-bit received character while data is present
// - with fifo enabled received characters pass through the receive fifo
// - transmit holding writes queue in the transmit fifo and shift out one by one
// - receive count shows characters held in receive fifo, reset zero
// - transmit count shows characters waiting in transmit fifo, reset zero
// - bit rate is reference clock over 16 over the 16-bit divisor
// - reference clock is twice system clock over low seven prescaler bits
// - station address resets to all ones, meaning no address assigned
// - address matching off when address is all ones or parity disabled
// - with matching on, characters are discarded until a matching address arrives
// - own or broadcast address raises the match event and opens reception
// - transmit start or station address write closes reception until next match
// - match event clears on event register read or leaving multi-drop mode
// - under automatic flow control send clear changes raise no modem event
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module usdba_top
  import usdba_pkg::*;
#(
  parameter bit PRIMARY_PORT = 1'b1
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // serial line
  input wire logic rxd_in,
  output logic txd_out,
  // modem inputs, active low
  input wire logic carrier_n_in,
  input wire logic ring_n_in,
  input wire logic set_ready_n_in,
  input wire logic send_clear_n_in,
  // event levels
  output logic addr_match_out,
  output logic modem_event_out
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic parity_of(input logic [7:0] data, input logic [1:0] wls, input logic [1:0] kind);
    logic [7:0] masked;
    masked = data & (8'hff >> (2'h3 - wls));
    unique case (kind)
      2'h0: parity_of = ~^masked;
      2'h1: parity_of = ^masked;
      2'h2: parity_of = 1'b1;
      2'h3: parity_of = 1'b0;
    endcase
  endfunction : parity_of

  function automatic logic [2:0] last_bit(input logic [1:0] wls);
    last_bit = `USDBA_MIN_BITS + {1'b0, wls};
  endfunction : last_bit

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  usdba_line_ctrl_t line_ctrl_reg;
  logic [15:0] baud_divisor_reg;
  logic [7:0] clock_prescaler_reg;
  logic [7:0] station_address_reg;
  logic [7:0] modem_pin_status;
  logic [3:0] modem_chg_reg;
  logic addr_match_reg;
  logic overrun_reg;
  logic [7:0] rd_value;
  logic [7:0] rd_cap_reg;
  logic mapped;
  logic setup;
  logic access;
  logic wr_access;
  logic rd_access;
  logic [7:0] rx_head;
  logic [3:0] rx_count;
  logic [3:0] tx_count;
  logic rx_empty;
  logic tx_empty;
  logic tx_full;
  logic rx_full;
  logic tx_idle;

  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in;
  assign wr_access = access && pwrite_in && mapped;
  assign rd_access = access && !pwrite_in && mapped;
  assign pready_out = 1'b1;
  assign pslverr_out = access && !mapped;

  always_comb begin
    mapped = 1'b1;
    rd_value = 8'h00;
    unique case (paddr_in)
      `USDBA_OFS_DATA: rd_value = rx_empty ? 8'h00 : rx_head;
      `USDBA_OFS_LINE_CTRL: rd_value = line_ctrl_reg;
      `USDBA_OFS_MODEM: rd_value = PRIMARY_PORT ? modem_pin_status : 8'h00;
      `USDBA_OFS_RX_COUNT: rd_value = {4'h0, rx_count};
      `USDBA_OFS_TX_COUNT: rd_value = {4'h0, tx_count};
      `USDBA_OFS_DIVISOR: rd_value = baud_divisor_reg[7:0];
      `USDBA_OFS_PRESCALER: rd_value = clock_prescaler_reg;
      `USDBA_OFS_STATION: rd_value = PRIMARY_PORT ? station_address_reg : 8'h00;
      `USDBA_OFS_EVENTS: rd_value = {4'h0, tx_idle && tx_empty, !rx_empty, overrun_reg, addr_match_reg};
      default: mapped = 1'b0;
    endcase
  end

  // captured in setup so that clear-on-read only
  // removes what software saw
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rd_cap_reg <= 8'h00;
      prdata_out <= 32'h00000000;
    end else if (setup) begin
      rd_cap_reg <= rd_value;
      prdata_out <= (paddr_in == `USDBA_OFS_DIVISOR) ? {16'h0000, baud_divisor_reg} : {24'h000000, rd_value};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      line_ctrl_reg <= `USDBA_RST_LINE_CTRL;
      baud_divisor_reg <= `USDBA_RST_DIVISOR;
      clock_prescaler_reg <= `USDBA_RST_PRESCALER;
      station_address_reg <= `USDBA_RST_STATION;
    end else if (wr_access) begin
      unique case (paddr_in)
        `USDBA_OFS_LINE_CTRL: line_ctrl_reg <= pwdata_in[7:0];
        `USDBA_OFS_DIVISOR: baud_divisor_reg <= pwdata_in[15:0];
        `USDBA_OFS_PRESCALER: clock_prescaler_reg <= pwdata_in[7:0] & `USDBA_PRESC_MASK;
        `USDBA_OFS_STATION: station_address_reg <= PRIMARY_PORT ? pwdata_in[7:0] : `USDBA_RST_STATION;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // modem inputs

  usdba_modem_t modem_meta_reg;
  usdba_modem_t modem_sync_reg;
  usdba_modem_t modem_last_reg;
  usdba_modem_t modem_edge;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      modem_meta_reg <= 4'h0;
      modem_sync_reg <= 4'h0;
      modem_last_reg <= 4'h0;
    end else begin
      modem_meta_reg <= ~{carrier_n_in, ring_n_in, set_ready_n_in, send_clear_n_in};
      modem_sync_reg <= modem_meta_reg;
      modem_last_reg <= modem_sync_reg;
    end
  end

  assign modem_edge = modem_sync_reg ^ modem_last_reg;
  assign modem_pin_status = {modem_sync_reg, modem_chg_reg};
  // cts steers the transmitter under auto flow
  assign modem_event_out = PRIMARY_PORT && ((|modem_chg_reg[3:1]) || (modem_chg_reg[0] && !line_ctrl_reg.auto_flow));

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in || !PRIMARY_PORT) begin
      modem_chg_reg <= 4'h0;
    end else begin
      // a fresh edge wins over the read clear
      modem_chg_reg <= (modem_chg_reg & ~((rd_access && paddr_in == `USDBA_OFS_MODEM) ? rd_cap_reg[3:0] : 4'h0))
        | modem_edge;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // baud and fifos

  logic tick;
  logic rx_push;
  logic [7:0] rx_char_reg;
  logic tx_pop;
  logic [7:0] tx_head;
  logic [3:0] depth_limit;
  logic rx_pop;
  logic tx_push;

  // fifo disabled behaves as a single holding register
  assign depth_limit = line_ctrl_reg.fifo_en ? `USDBA_FIFO_DEPTH : `USDBA_FIFO_ONE;
  assign rx_pop = rd_access && paddr_in == `USDBA_OFS_DATA;
  assign tx_push = wr_access && paddr_in == `USDBA_OFS_DATA && !tx_full;

  usdba_baud baud_gen (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .presc_in(clock_prescaler_reg),
    .divisor_in(baud_divisor_reg),
    .tick_out(tick)
  );

  usdba_fifo rx_fifo (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .push_in(rx_push),
    .data_in(rx_char_reg),
    .pop_in(rx_pop),
    .limit_in(depth_limit),
    .data_out(rx_head),
    .count_out(rx_count),
    .full_out(rx_full),
    .empty_out(rx_empty)
  );

  usdba_fifo tx_fifo (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .push_in(tx_push),
    .data_in(pwdata_in[7:0]),
    .pop_in(tx_pop),
    .limit_in(depth_limit),
    .data_out(tx_head),
    .count_out(tx_count),
    .full_out(tx_full),
    .empty_out(tx_empty)
  );

  //////////////////////////////////////////////////////////////////////////////
  // transmitter

  usdba_ser_state_t tx_state_reg;
  logic [3:0] tx_os_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic tx_second_stop_reg;
  logic tx_start;

  assign tx_idle = tx_state_reg == SER_IDLE;
  assign tx_start = tx_idle && tick && !tx_empty && (!line_ctrl_reg.auto_flow || modem_sync_reg.send_clear);
  assign tx_pop = tx_start;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      tx_state_reg <= SER_IDLE;
      tx_os_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_second_stop_reg <= 1'b0;
      txd_out <= 1'b1;
    end else if (tick) begin
      tx_os_reg <= tx_os_reg + 4'h1;
      unique case (tx_state_reg)
        SER_IDLE: begin
          tx_os_reg <= 4'h0;
          if (tx_start) begin
            tx_shift_reg <= tx_head;
            tx_state_reg <= SER_START;
            txd_out <= 1'b0;
          end
        end
        SER_START: begin
          if (tx_os_reg == `USDBA_FULL_BIT) begin
            tx_state_reg <= SER_DATA;
            tx_bit_reg <= 3'h0;
            txd_out <= tx_shift_reg[0];
          end
        end
        SER_DATA: begin
          if (tx_os_reg == `USDBA_FULL_BIT) begin
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (tx_bit_reg == last_bit(line_ctrl_reg.word_length_sel)) begin
              tx_state_reg <= line_ctrl_reg.parity_enable ? SER_PAR : SER_STOP;
              txd_out <= line_ctrl_reg.parity_enable
                ? parity_of(tx_shift_reg, line_ctrl_reg.word_length_sel, line_ctrl_reg.parity_kind_sel) : 1'b1;
              tx_second_stop_reg <= line_ctrl_reg.two_stop;
            end else begin
              txd_out <= tx_shift_reg[tx_bit_reg + 3'h1];
            end
          end
        end
        SER_PAR: begin
          if (tx_os_reg == `USDBA_FULL_BIT) begin
            tx_state_reg <= SER_STOP;
            txd_out <= 1'b1;
          end
        end
        SER_STOP: begin
          if (tx_os_reg == `USDBA_FULL_BIT) begin
            tx_second_stop_reg <= 1'b0;
            if (!tx_second_stop_reg) begin
              tx_state_reg <= SER_IDLE;
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver

  usdba_ser_state_t rx_state_reg;
  logic [3:0] rx_os_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic rx_ninth_reg;
  logic rx_done_reg;
  logic rx_ninth_done_reg;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rx_state_reg <= SER_IDLE;
      rx_os_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_ninth_reg <= 1'b0;
      rx_done_reg <= 1'b0;
      rx_char_reg <= 8'h00;
      rx_ninth_done_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (tick) begin
        rx_os_reg <= rx_os_reg + 4'h1;
        unique case (rx_state_reg)
          SER_IDLE: begin
            rx_os_reg <= 4'h0;
            if (!rxd_in) begin
              rx_state_reg <= SER_START;
              rx_shift_reg <= 8'h00;
            end
          end
          SER_START: begin
            // mid-start check rejects glitches; later samples land mid-bit
            if (rx_os_reg == `USDBA_HALF_BIT) begin
              rx_os_reg <= 4'h0;
              rx_bit_reg <= 3'h0;
              rx_state_reg <= rxd_in ? SER_IDLE : SER_DATA;
            end
          end
          SER_DATA: begin
            if (rx_os_reg == `USDBA_FULL_BIT) begin
              rx_shift_reg[rx_bit_reg] <= rxd_in;
              rx_bit_reg <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == last_bit(line_ctrl_reg.word_length_sel)) begin
                rx_state_reg <= line_ctrl_reg.parity_enable ? SER_PAR : SER_STOP;
              end
            end
          end
          SER_PAR: begin
            if (rx_os_reg == `USDBA_FULL_BIT) begin
              rx_ninth_reg <= rxd_in;
              rx_state_reg <= SER_STOP;
            end
          end
          SER_STOP: begin
            if (rx_os_reg == `USDBA_FULL_BIT) begin
              rx_state_reg <= SER_IDLE;
              rx_done_reg <= 1'b1;
              rx_char_reg <= rx_shift_reg;
              rx_ninth_done_reg <= rx_ninth_reg;
            end
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // station address matching

  logic match_en;
  logic match_en_last_reg;
  logic is_address;
  logic addr_hit;
  logic listen_reg;

  assign match_en = PRIMARY_PORT && station_address_reg != `USDBA_NO_ADDRESS && line_ctrl_reg.parity_enable;
  // kind 10b: address has a clear ninth bit; 11b: a set one
  assign is_address = rx_ninth_done_reg == line_ctrl_reg.parity_kind_sel[0];
  assign addr_hit = rx_done_reg && match_en && is_address
    && (rx_char_reg == station_address_reg || rx_char_reg == `USDBA_NO_ADDRESS);
  // address characters are not queued in match mode
  assign rx_push = rx_done_reg && !rx_full && (!match_en || (listen_reg && !is_address));
  assign addr_match_out = addr_match_reg;

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      listen_reg <= 1'b0;
    end else if (addr_hit) begin
      listen_reg <= 1'b1;
    end else if (tx_start || (wr_access && paddr_in == `USDBA_OFS_STATION)
        || (rx_done_reg && match_en && is_address)) begin
      listen_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      match_en_last_reg <= 1'b0;
      addr_match_reg <= 1'b0;
    end else begin
      match_en_last_reg <= match_en;
      if (addr_hit) begin
        addr_match_reg <= 1'b1;
      end else if ((match_en_last_reg && !match_en)
          || (rd_access && paddr_in == `USDBA_OFS_EVENTS && rd_cap_reg[`USDBA_EV_MATCH])) begin
        addr_match_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      overrun_reg <= 1'b0;
    end else if (rx_done_reg && rx_full) begin
      overrun_reg <= 1'b1;
    end else if (rd_access && paddr_in == `USDBA_OFS_EVENTS && rd_cap_reg[`USDBA_EV_OVERRUN]) begin
      overrun_reg <= 1'b0;
    end
  end
endmodule : usdba_top

// [sim/usdba_properties.sv]
// usdba_properties: pin-level checks of the serial port top
// assumes a bind to usdba_top, one clock, synchronous low reset
`timescale 1ns/1ps
module usdba_properties
  import usdba_pkg::*;
(
  // clock, reset and apb
  input wire logic sys_clk_in, reset_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in, prdata_out,
  // line, modem and events
  input wire logic txd_out, carrier_n_in, ring_n_in, set_ready_n_in, send_clear_n_in,
  input wire logic addr_match_out, modem_event_out
);
  logic [3:0] pins, pins_reg;
  logic [2:0] calm_reg;
  logic acc, rd;
  assign pins = {carrier_n_in, ring_n_in, set_ready_n_in, send_clear_n_in};
  assign acc = psel_in && penable_in;
  assign rd = psel_in && !pwrite_in;
  // cycles the modem pins held still, saturating
  always_ff @(posedge sys_clk_in) begin
    pins_reg <= pins;
    if (!reset_n_in || pins != pins_reg) begin
      calm_reg <= 3'h0;
    end else if (calm_reg != 3'h7) begin
      calm_reg <= calm_reg + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  chk_level_flags: assert property (rd && !penable_in && paddr_in == 8'h08 && calm_reg >= 3'h5
    |=> prdata_out[7:4] == ~$past(pins)) else $error("modem levels wrong");
  chk_change_sets: assert property ($changed(pins[3:1]) |-> ##[1:5] modem_event_out)
    else $error("modem change missed");
  chk_read_clears: assert property (acc && rd && paddr_in == 8'h08 && calm_reg >= 3'h6
    |=> !modem_event_out) else $error("modem not cleared");
  chk_match_rd_clear: assert property (acc && rd && paddr_in == 8'h20 |=> !addr_match_out)
    else $error("match event not cleared");
  chk_unassign_clears: assert property (acc && pwrite_in && paddr_in == 8'h1c && pwdata_in[7:0] == 8'hff
    |-> ##[1:2] !addr_match_out) else $error("match kept");
  chk_tx_bit_width: assert property ($fell(txd_out) |-> !txd_out [*8])
    else $error("bit too short");
  chk_count_range: assert property (acc && rd && (paddr_in == 8'h0c || paddr_in == 8'h10)
    |-> prdata_out <= 32'h8) else $error("count out of range");
  chk_unmapped_err: assert property (acc && paddr_in > 8'h20 |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped not refused");
endmodule : usdba_properties

bind usdba_top usdba_properties u_props (.sys_clk_in, .reset_n_in, .psel_in, .penable_in,
  .pwrite_in, .pready_out, .pslverr_out, .paddr_in, .pwdata_in, .prdata_out, .txd_out,
  .carrier_n_in, .ring_n_in, .set_ready_n_in, .send_clear_n_in, .addr_match_out, .modem_event_out);

// [sim/usdba_remote_station.sv]
// usdba_remote_station: far station on the serial line
// assumes BIT_CYC system clocks per bit and 8 data bits on receive
`timescale 1ns/1ps
module usdba_remote_station #(
  parameter int BIT_CYC = 16
) (
  // clock and line
  input wire logic sys_clk_in,
  input wire logic txd_in,
  output logic rxd_out
);
  logic [7:0] got_q[$];
  logic [7:0] rx_byte;
  logic [10:0] frame;
  initial rxd_out = 1'b1;
  // start, data lsb first, optional ninth bit, one stop; line idles high
  task automatic send(input logic [7:0] ch, input logic use9, input logic b9);
    frame = use9 ? {1'b1, b9, ch, 1'b0} : {2'b11, ch, 1'b0};
    for (int i = 0; i < (use9 ? 11 : 10); i++) begin
      @(posedge sys_clk_in);
      rxd_out <= frame[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk_in);
    end
  endtask : send
  // mid-bit sampling at BIT_CYC
  always begin
    @(negedge txd_in);
    repeat (BIT_CYC / 2) @(posedge sys_clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk_in);
      rx_byte[i] = txd_in;
    end
    got_q.push_back(rx_byte);
    repeat (BIT_CYC) @(posedge sys_clk_in);
  end
endmodule : usdba_remote_station

// [sim/usdba_top_tb_top.sv]
// usdba_top_tb_top: self-checking bench for the serial port
// assumes the remote station model and the bound checker
`timescale 1ns/1ps
module usdba_top_tb_top;
  logic sys_clk_in = 1'b0, reset_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic carrier_n_in = 1'b1, ring_n_in = 1'b1, set_ready_n_in = 1'b1, send_clear_n_in = 1'b1;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rdat, rnd;
  logic pready_out, pslverr_out, rxd_in, txd_out, addr_match_out, modem_event_out, serr;
  logic [7:0] txb[3];
  logic [3:0] prev, nxt;
  int err_count = 0, n_tests = 0, cycles = 0, seed = 2, p, i;

  always #4 sys_clk_in = ~sys_clk_in;
  usdba_top u_usdba_top (.sys_clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .rxd_in, .txd_out, .carrier_n_in,
    .ring_n_in, .set_ready_n_in, .send_clear_n_in, .addr_match_out, .modem_event_out);
  usdba_remote_station u_far (.sys_clk_in, .txd_in(txd_out), .rxd_out(rxd_in));

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    @(posedge sys_clk_in);
    while (pready_out !== 1'b1) @(posedge sys_clk_in);
    rdat = prdata_out;
    serr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd_chk
  task automatic match_is(input logic exp);
    repeat (2) @(negedge sys_clk_in);
    chk({31'h0, addr_match_out}, {31'h0, exp});
  endtask : match_is
  task automatic done(input string s);
    $display("%s done", s);
  endtask : done
  function automatic logic [7:0] msr_exp(input logic [3:0] now, input logic [3:0] was);
    return {~now, now ^ was};
  endfunction : msr_exp
  function automatic int bit_cycles(input int pr, input int dv);
    return 8 * pr * dv;
  endfunction : bit_cycles
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      $display("[FAIL] %0t run did not finish", $time);
      complete_run();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    rd_chk(8'h0c, 32'h0);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h1c, 32'hff);
    rd_chk(8'h24, 32'h0);
    chk({31'h0, serr}, 32'h1);
    done("reset");
    rnd = $random(seed);
    p = rnd[1:0] + 1;
    apb(1'b1, 8'h18, 32'hff);
    rd_chk(8'h18, 32'h7f);
    apb(1'b1, 8'h14, {16'h0, rnd[31:16]});
    rd_chk(8'h14, {16'h0, rnd[31:16]});
    apb(1'b1, 8'h18, 32'(p));
    apb(1'b1, 8'h14, 32'h2);
    apb(1'b1, 8'h00, 32'hff);
    wait (txd_out === 1'b0);
    i = 0;
    @(negedge sys_clk_in);
    while (txd_out === 1'b0) begin
      i++;
      @(negedge sys_clk_in);
    end
    chk(i, bit_cycles(p, 2));
    do apb(1'b0, 8'h20, 32'h0); while (rdat[3] !== 1'b1);
    done("rate");
    repeat (160) @(posedge sys_clk_in);
    // zero divisor holds the queue
    apb(1'b1, 8'h04, 32'h43);
    apb(1'b1, 8'h18, 32'h2);
    apb(1'b1, 8'h14, 32'h0);
    u_far.got_q.delete();
    for (int k = 0; k < 3; k++) begin
      rnd = $random(seed);
      txb[k] = rnd[7:0];
      apb(1'b1, 8'h00, {24'h0, txb[k]});
    end
    rd_chk(8'h10, 32'h3);
    apb(1'b1, 8'h14, 32'h1);
    while (u_far.got_q.size() < 3) @(posedge sys_clk_in);
    for (int k = 0; k < 3; k++) chk({24'h0, u_far.got_q[k]}, {24'h0, txb[k]});
    done("transmit");
    rnd = $random(seed);
    u_far.send(rnd[7:0], 1'b0, 1'b0);
    u_far.send(rnd[15:8], 1'b0, 1'b0);
    rd_chk(8'h0c, 32'h2);
    rd_chk(8'h00, {24'h0, rnd[7:0]});
    rd_chk(8'h0c, 32'h1);
    rd_chk(8'h00, {24'h0, rnd[15:8]});
    rd_chk(8'h0c, 32'h0);
    done("receive");
    apb(1'b1, 8'h04, 32'h6b);
    apb(1'b1, 8'h1c, 32'h5a);
    u_far.send(8'h11, 1'b1, 1'b1);
    u_far.send(8'h33, 1'b1, 1'b0);
    rd_chk(8'h0c, 32'h0);
    match_is(1'b0);
    u_far.send(8'h5a, 1'b1, 1'b0);
    match_is(1'b1);
    u_far.send(rnd[23:16], 1'b1, 1'b1);
    rd_chk(8'h00, {24'h0, rnd[23:16]});
    rd_chk(8'h20, 32'h9);
    match_is(1'b0);
    apb(1'b1, 8'h1c, 32'h5a);
    u_far.send(8'h22, 1'b1, 1'b1);
    rd_chk(8'h0c, 32'h0);
    u_far.send(8'hff, 1'b1, 1'b0);
    match_is(1'b1);
    apb(1'b1, 8'h1c, 32'hff);
    match_is(1'b0);
    u_far.send(8'h44, 1'b1, 1'b1);
    rd_chk(8'h0c, 32'h1);
    done("address");
    prev = 4'hf;
    apb(1'b0, 8'h08, 32'h0);
    for (int k = 0; k < 6; k++) begin
      rnd = $random(seed);
      nxt = (k == 0) ? 4'h0 : rnd[3:0];
      {carrier_n_in, ring_n_in, set_ready_n_in, send_clear_n_in} <= nxt;
      repeat (8) @(posedge sys_clk_in);
      rd_chk(8'h08, {24'h0, msr_exp(nxt, prev)});
      prev = nxt;
    end
    apb(1'b1, 8'h04, 32'heb);
    apb(1'b0, 8'h08, 32'h0);
    send_clear_n_in <= ~prev[0];
    repeat (8) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    chk({31'h0, modem_event_out}, 32'h0);
    done("modem");
    complete_run();
  end
endmodule : usdba_top_tb_top
